/* pkg/rbt_pkg.sv */
package rbt_pkg;
   localparam int RBT_WIDTH = 18;
   localparam int RBT_HALF = 9;
   localparam int RBT_FIFO_DEPTH = 4;
   localparam logic [1:0] RBT_DIR_FWD = 2'h0;
   localparam logic [1:0] RBT_DIR_REV = 2'h1;
endpackage

/* hdl/rbt_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module rbt_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   // refuse depths that the natural pointer wrap cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
   end

   // honest flags straight from the count
   assign in_ready_o = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // pointer and count next values
   always_comb
   begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count;
      if (push && !pop)
         next_count = count + 1'b1;
      else if (pop && !push)
         next_count = count - 1'b1;
   end

   // storage has no reset, only the pointers and the count do
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push)
         mem[wr_ptr] <= in_data_i;
   end
endmodule
`default_nettype wire

/* hdl/rbt_transceiver.sv */
// Contract
// - 18-bit register in each direction
// - two 9-bit halves, own clock enables
// - one output enable, one clock per direction
// - enabled half captures A on fwd edge
// - disabled half or steady clock holds
// - fwd enable low drives B from register
// - fwd enable high isolates B
// - reverse direction mirrors forward
// - A inputs only retimed, not held at last level
`timescale 1ns/100ps
`default_nettype none
module rbt_transceiver
   import rbt_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic fwd_clk_i,
   input wire logic rev_clk_i,
   input wire logic fwd_out_en_n_i,
   input wire logic rev_out_en_n_i,
   input wire logic low_half_fwd_clk_en_n_i,
   input wire logic high_half_fwd_clk_en_n_i,
   input wire logic low_half_rev_clk_en_n_i,
   input wire logic high_half_rev_clk_en_n_i,
   input wire logic [RBT_WIDTH-1:0] a_in_i,
   output logic [RBT_WIDTH-1:0] a_out_o,
   output logic a_oe_n_o,
   input wire logic [RBT_WIDTH-1:0] b_in_i,
   output logic [RBT_WIDTH-1:0] b_out_o,
   output logic b_oe_n_o
);
   // two-stage synchronisers; pins are asynchronous to clk_i
   logic [RBT_WIDTH-1:0] a_s1, a_s2, b_s1, b_s2;
   logic [RBT_WIDTH-1:0] a_hold;
   logic [RBT_WIDTH-1:0] next_a_hold;
   logic [7:0] ctl_s1, ctl_s2;
   logic fwd_clk_d, rev_clk_d;
   logic fwd_edge, rev_edge;
   logic [1:0] fwd_en, rev_en;
   logic [RBT_WIDTH-1:0] fwd_reg, rev_reg;
   logic [RBT_WIDTH-1:0] next_fwd_reg, next_rev_reg;
   logic fwd_push, fwd_ready, fifo_valid;
   logic [RBT_WIDTH-1:0] fifo_data;
   logic next_a_oe_n, next_b_oe_n;
   logic [RBT_WIDTH-1:0] next_b_out;

   always_ff @(posedge clk_i)
   begin
      a_s1 <= a_in_i;
      a_s2 <= a_s1;
      b_s1 <= b_in_i;
      b_s2 <= b_s1;
      ctl_s1 <= {fwd_clk_i, rev_clk_i, fwd_out_en_n_i, rev_out_en_n_i,
                 low_half_fwd_clk_en_n_i, high_half_fwd_clk_en_n_i,
                 low_half_rev_clk_en_n_i, high_half_rev_clk_en_n_i};
      ctl_s2 <= ctl_s1;
   end

   // edge detect reads only the second stage
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         fwd_clk_d <= 1'b0;
         rev_clk_d <= 1'b0;
      end
      else
      begin
         fwd_clk_d <= ctl_s2[7];
         rev_clk_d <= ctl_s2[6];
      end
   end

   assign fwd_edge = ctl_s2[7] && !fwd_clk_d;
   assign rev_edge = ctl_s2[6] && !rev_clk_d;
   assign fwd_en = {!ctl_s2[2], !ctl_s2[3]};
   assign rev_en = {!ctl_s2[0], !ctl_s2[1]};

   // bus keeper: A value that an undriven pin would keep
   // the pin is split into in and out, so here the keeper only retimes A
   always_comb
   begin
      next_a_hold = a_s2;
   end

   always_ff @(posedge clk_i)
   begin
      a_hold <= next_a_hold;
   end

   // one half-select capture used by both directions
   function automatic logic [RBT_WIDTH-1:0] capture(
      input logic [RBT_WIDTH-1:0] old_q,
      input logic [RBT_WIDTH-1:0] d,
      input logic edge_seen,
      input logic [1:0] half_en
   );
      logic [RBT_WIDTH-1:0] q;
      q = old_q;
      if (edge_seen && half_en[0])
         q[RBT_HALF-1:0] = d[RBT_HALF-1:0];
      if (edge_seen && half_en[1])
         q[RBT_WIDTH-1:RBT_HALF] = d[RBT_WIDTH-1:RBT_HALF];
      return q;
   endfunction

   // forward capture goes through the fifo, so a full fifo drops it
   assign fwd_push = fwd_edge && (fwd_en != 2'h0);

   rbt_fifo #(
      .WIDTH(RBT_WIDTH),
      .DEPTH(RBT_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_data_i(capture(fwd_reg, a_hold, 1'b1, fwd_en)),
      .in_valid_i(fwd_push),
      .in_ready_o(fwd_ready),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(1'b1)
   );

   // register next values; no reset on data
   always_comb
   begin
      next_fwd_reg = capture(fwd_reg, a_hold, fwd_push && fwd_ready, fwd_en);
      next_rev_reg = capture(rev_reg, b_s2, rev_edge, rev_en);
      next_b_out = fifo_valid ? fifo_data : b_out_o;
      next_b_oe_n = ctl_s2[5];
      next_a_oe_n = ctl_s2[4];
   end

   always_ff @(posedge clk_i)
   begin
      fwd_reg <= next_fwd_reg;
      rev_reg <= next_rev_reg;
      b_out_o <= next_b_out;
      a_out_o <= next_rev_reg;
   end

   // enables reset to isolation so no pin fights the bus
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         a_oe_n_o <= 1'b1;
         b_oe_n_o <= 1'b1;
      end
      else
      begin
         a_oe_n_o <= next_a_oe_n;
         b_oe_n_o <= next_b_oe_n;
      end
   end

   // enables follow the synchronised pins one clock late
   chk_iso_fwd: assert property (@(posedge clk_i) disable iff (reset_i)
      ctl_s2[5] |=> b_oe_n_o)
      else $error("B not isolated");
   chk_drive_fwd: assert property (@(posedge clk_i) disable iff (reset_i)
      !ctl_s2[5] |=> !b_oe_n_o)
      else $error("B not driven");
   chk_iso_rev: assert property (@(posedge clk_i) disable iff (reset_i)
      ctl_s2[4] |=> a_oe_n_o)
      else $error("A not isolated");
   chk_drive_rev: assert property (@(posedge clk_i) disable iff (reset_i)
      !ctl_s2[4] |=> !a_oe_n_o)
      else $error("A not driven");

   // registers and outputs move only after a direction clock edge
   chk_hold_fwd: assert property (@(posedge clk_i) disable iff (reset_i)
      !fwd_edge |=> $stable(fwd_reg))
      else $error("fwd reg changed");
   chk_hold_rev: assert property (@(posedge clk_i) disable iff (reset_i)
      !rev_edge |=> $stable(rev_reg))
      else $error("rev reg changed");
   chk_a_out_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      !rev_edge |=> $stable(a_out_o))
      else $error("A out changed");
   chk_b_out_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      !fifo_valid |=> $stable(b_out_o))
      else $error("B out changed");

   // each half captures only while its own enable is low
   chk_low_cap: assert property (@(posedge clk_i) disable iff (reset_i)
      fwd_push && fwd_ready && fwd_en[0] |=>
         fwd_reg[RBT_HALF-1:0] == $past(a_hold[RBT_HALF-1:0]))
      else $error("low half not captured");
   chk_high_cap: assert property (@(posedge clk_i) disable iff (reset_i)
      fwd_push && fwd_ready && fwd_en[1] |=>
         fwd_reg[RBT_WIDTH-1:RBT_HALF] == $past(a_hold[RBT_WIDTH-1:RBT_HALF]))
      else $error("high half not captured");
   chk_high_keep: assert property (@(posedge clk_i) disable iff (reset_i)
      fwd_edge && !fwd_en[1] |=> $stable(fwd_reg[RBT_WIDTH-1:RBT_HALF]))
      else $error("high half changed");
   chk_rev_low_keep: assert property (@(posedge clk_i) disable iff (reset_i)
      rev_edge && !rev_en[0] |=> $stable(rev_reg[RBT_HALF-1:0]))
      else $error("rev low half changed");
   chk_rev_cap: assert property (@(posedge clk_i) disable iff (reset_i)
      rev_edge && rev_en == 2'h3 |=> rev_reg == $past(b_s2))
      else $error("rev not captured");
   chk_rev_high_cap: assert property (@(posedge clk_i) disable iff (reset_i)
      rev_edge && rev_en[1] |=>
         rev_reg[RBT_WIDTH-1:RBT_HALF] == $past(b_s2[RBT_WIDTH-1:RBT_HALF]))
      else $error("rev high half not captured");
   chk_rev_out: assert property (@(posedge clk_i) disable iff (reset_i)
      rev_edge && rev_en == 2'h3 |=> a_out_o == $past(b_s2))
      else $error("A out mismatch");

   // forward word reaches B two clocks after capture, never dropped
   chk_no_loss: assert property (@(posedge clk_i) disable iff (reset_i)
      fwd_push |-> fwd_ready)
      else $error("fwd capture lost");
   chk_b_path: assert property (@(posedge clk_i) disable iff (reset_i)
      fwd_push && fwd_en == 2'h3 |=> ##1 b_out_o == $past(a_hold, 2))
      else $error("B out mismatch");
endmodule
`default_nettype wire

/* tb/rbt_far_side.sv */
`timescale 1ns/100ps
`default_nettype none
// far-side party on one port; resolves the shared wire
module rbt_far_side
   import rbt_pkg::*;
(
   input wire logic clk_i,
   input wire logic [RBT_WIDTH-1:0] dev_val_i,
   input wire logic dev_oe_n_i,
   input wire logic [RBT_WIDTH-1:0] drv_val_i,
   input wire logic drv_en_i,
   output logic [RBT_WIDTH-1:0] wire_o
);
   logic [RBT_WIDTH-1:0] last = '0;
   // released wire toggles so a stale value never passes
   always_comb
   begin
      if (!dev_oe_n_i) wire_o = dev_val_i;
      else if (drv_en_i) wire_o = drv_val_i;
      else wire_o = ~last;
   end
   always_ff @(posedge clk_i)
   begin
      last <= wire_o;
   end
endmodule
`default_nettype wire

/* tb/registered_bidir_bus_transceiver_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module registered_bidir_bus_transceiver_bench;
   import rbt_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic fwd_clk = 1'b0;
   logic rev_clk = 1'b0;
   logic fwd_oe_n = 1'b1;
   logic rev_oe_n = 1'b1;
   logic [3:0] ce_n = 4'hF;
   logic [RBT_WIDTH-1:0] a_drv = '0;
   logic [RBT_WIDTH-1:0] b_drv = '0;
   logic [RBT_WIDTH-1:0] a_w, b_w, a_out, b_out, fwd_exp, rev_exp;
   logic a_oe_n, b_oe_n;
   logic [31:0] seed = 32'h635E;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   rbt_transceiver dut (.clk_i(clk_i), .reset_i(reset_i), .fwd_clk_i(fwd_clk),
      .rev_clk_i(rev_clk), .fwd_out_en_n_i(fwd_oe_n), .rev_out_en_n_i(rev_oe_n),
      .low_half_fwd_clk_en_n_i(ce_n[0]), .high_half_fwd_clk_en_n_i(ce_n[1]),
      .low_half_rev_clk_en_n_i(ce_n[2]), .high_half_rev_clk_en_n_i(ce_n[3]),
      .a_in_i(a_w), .a_out_o(a_out), .a_oe_n_o(a_oe_n),
      .b_in_i(b_w), .b_out_o(b_out), .b_oe_n_o(b_oe_n));
   rbt_far_side card (.clk_i(clk_i), .dev_val_i(a_out), .dev_oe_n_i(a_oe_n),
      .drv_val_i(a_drv), .drv_en_i(1'b1), .wire_o(a_w));
   rbt_far_side plane (.clk_i(clk_i), .dev_val_i(b_out), .dev_oe_n_i(b_oe_n),
      .drv_val_i(b_drv), .drv_en_i(1'b1), .wire_o(b_w));
   // clock
   always #20 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // a disabled half keeps its old contents
   function automatic logic [RBT_WIDTH-1:0] merge(input logic [RBT_WIDTH-1:0] o,
      input logic [RBT_WIDTH-1:0] d, input logic [1:0] ce);
      return {ce[1] ? o[17:9] : d[17:9], ce[0] ? o[8:0] : d[8:0]};
   endfunction
   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic check(input string name, input logic [RBT_WIDTH-1:0] exp,
      input logic [RBT_WIDTH-1:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask
   task automatic results();
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one capture in one direction, then drive, then isolate
   task automatic xfer(input logic dir, input logic [1:0] ce);
      seed = lfsr(seed);
      step(1);
      if (!dir) a_drv = seed[RBT_WIDTH-1:0];
      else b_drv = seed[RBT_WIDTH-1:0];
      if (!dir) fwd_exp = merge(fwd_exp, seed[RBT_WIDTH-1:0], ce);
      else rev_exp = merge(rev_exp, seed[RBT_WIDTH-1:0], ce);
      if (!dir) ce_n[1:0] = ce;
      else ce_n[3:2] = ce;
      step(1);
      if (!dir) fwd_clk = 1'b1;
      else rev_clk = 1'b1;
      step(4);
      fwd_clk = 1'b0;
      rev_clk = 1'b0;
      step(4);
      // inputs move while the clock stands still
      seed = lfsr(seed);
      a_drv = seed[RBT_WIDTH-1:0];
      b_drv = ~seed[RBT_WIDTH-1:0];
      ce_n = 4'h0;
      step(2);
      ce_n = 4'hF;
      fwd_oe_n = dir;
      rev_oe_n = !dir;
      step(5);
      if (!dir) check("b_oe_n", 0, b_oe_n);
      if (!dir) check("b_out", fwd_exp, b_out);
      if (dir) check("a_oe_n", 0, a_oe_n);
      if (dir) check("a_out", rev_exp, a_out);
      fwd_oe_n = 1'b1;
      rev_oe_n = 1'b1;
      step(5);
      check("b_oe_n", 1, b_oe_n);
      check("a_oe_n", 1, a_oe_n);
   endtask
   // hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         results();
      end
   end
   initial
   begin
      step(2);
      reset_i = 1'b0;
      step(3);
      check("b_oe_n", 1, b_oe_n);
      check("a_oe_n", 1, a_oe_n);
      xfer(1'b0, 2'h0);
      xfer(1'b1, 2'h0);
      xfer(1'b0, 2'h3);
      xfer(1'b1, 2'h3);
      for (int i = 0; i < 24; i++)
      begin
         seed = lfsr(seed);
         xfer(seed[0], seed[2:1]);
      end
      results();
   end
endmodule
`default_nettype wire
